// >>> include/pws_slave_regs.vh
// timing constants for the pulse-width single-wire sensor slave
// assumes a 250 MHz core clock; times in ns unless named _ms, counts named _CYC are core clock cycles
`ifndef PWS_SLAVE_REGS_VH
`define PWS_SLAVE_REGS_VH
`define CLK_PERIOD_NS 4
// idle_high_minimum, 11 us, least time, rounded up
`define IDLE_HIGH_MIN_NS 11000
`define IDLE_HIGH_MIN_CYC ((`IDLE_HIGH_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// host_short_pulse_time 11.8..17.0 us
`define HOST_SHORT_MIN_NS 11800
`define HOST_SHORT_MAX_NS 17000
// host_long_pulse_time 35.4..48.9 us
`define HOST_LONG_MIN_NS 35400
`define HOST_LONG_MAX_NS 48900
// edge_detect_latency 9.6 us, longest, rounded down
`define EDGE_DETECT_NS 9600
`define EDGE_DETECT_CYC (`EDGE_DETECT_NS / `CLK_PERIOD_NS)
// slave_read_one_pulse 28.3..38.3 us, our own drive lasts 33 us
`define READ_ONE_NS 33000
`define READ_ONE_CYC (`READ_ONE_NS / `CLK_PERIOD_NS)
// host_frame_begin_pulse 80..109 us
`define FRAME_BEGIN_MIN_NS 80000
`define FRAME_BEGIN_MAX_NS 109000
// slave_alert_pulse 165..228 us, we drive 196 us
`define ALERT_NS 196000
`define ALERT_CYC (`ALERT_NS / `CLK_PERIOD_NS)
// bus reset pulse, least 354 us, we drive 400 us
`define RESET_MIN_NS 354000
`define RESET_DRIVE_NS 400000
`define RESET_DRIVE_CYC (`RESET_DRIVE_NS / `CLK_PERIOD_NS)
// power-up drive limit 500 ms
`define POWERUP_MAX_MS 500
// monitoring_cycle_time 163.8..200.2 ms, typical 182
`define MONITOR_CYCLE_MS 182
`define MONITOR_CYCLE_CYC (`MONITOR_CYCLE_MS * 250000)
// classification thresholds, midway between windows
`define TH_ONE_NS 26000
`define TH_START_NS 64000
`define TH_ALERT_NS 137000
`define TH_RESET_NS 291000
`define TH_ONE_CYC (`TH_ONE_NS / `CLK_PERIOD_NS)
`define TH_START_CYC (`TH_START_NS / `CLK_PERIOD_NS)
`define TH_ALERT_CYC (`TH_ALERT_NS / `CLK_PERIOD_NS)
`define TH_RESET_CYC (`TH_RESET_NS / `CLK_PERIOD_NS)
// symbol codes
`define SYM_ZERO 3'h0
`define SYM_ONE 3'h1
`define SYM_START 3'h2
`define SYM_ALERT 3'h3
`define SYM_RESET 3'h4
// data bits required after a bus reset before any alert
`define BITS_BEFORE_ALERT 14
`endif

// >>> rtl/pulse_classifier.v
// low-pulse width classifier for the single-wire line
// assumes a synchronised line level on the core clock
`timescale 1ns/1ns
`include "pws_slave_regs.vh"
module pulse_classifier #(
  parameter CNT_W = 20
) (
  input wire core_clk_i,
  input wire rst_i,
  input wire line_low_i,
  output reg fall_o,
  output reg sym_valid_o,
  output reg [2:0] sym_code_o,
  output reg [CNT_W-1:0] low_cnt_o
);
  reg low_d_reg;

  // ***********************************
  // width measurement and decode
  // ***********************************
  // measure each low interval and decode at its end
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      low_d_reg <= 1'b0;
      fall_o <= 1'b0;
      sym_valid_o <= 1'b0;
      sym_code_o <= `SYM_ZERO;
      low_cnt_o <= {CNT_W{1'b0}};
    end else begin
      low_d_reg <= line_low_i;
      fall_o <= line_low_i & ~low_d_reg;
      sym_valid_o <= 1'b0;
      if (line_low_i) begin
        if (~&low_cnt_o) begin
          low_cnt_o <= low_cnt_o + 1'b1;
        end
      end else begin
        low_cnt_o <= {CNT_W{1'b0}};
        if (low_d_reg) begin
          sym_valid_o <= 1'b1;
          if (low_cnt_o >= `TH_RESET_CYC) begin
            sym_code_o <= `SYM_RESET;
          end else if (low_cnt_o >= `TH_ALERT_CYC) begin
            sym_code_o <= `SYM_ALERT;
          end else if (low_cnt_o >= `TH_START_CYC) begin
            sym_code_o <= `SYM_START;
          end else if (low_cnt_o >= `TH_ONE_CYC) begin
            sym_code_o <= `SYM_ONE;
          end else begin
            sym_code_o <= `SYM_ZERO;
          end
        end
      end
    end
  end
endmodule // pulse_classifier

// >>> rtl/pulse_width_sensor_bus_slave.v
// slave end of a single-wire pulse-width sensor bus
// assumes an external pull-up; line is open drain, output enable pulls low
//
// What this block does
// - alert waits for 11 us idle high
// - falling edge seen within 9.6 us
// - read one: drive low 28.3-38.3 us
// - alert pulse drives low 165-228 us
// - bus reset lasts at least 354 us
// - power-up drive released within 500 ms
// - temperature refreshed once per monitoring cycle
// - two pins select one of four addresses
// - symbols carried only by low width
// - shutdown mode and selectable conversion rate
// - read zero leaves line undriven
// - no alert until 14 data bits after reset
// - start mid transaction aborts it
`timescale 1ns/1ns
`include "pws_slave_regs.vh"
module pulse_width_sensor_bus_slave #(
  parameter CNT_W = 20,
  parameter MON_W = 28,
  parameter RESET_DRIVE_CYC = `RESET_DRIVE_CYC,
  parameter MONITOR_CYCLE_CYC = `MONITOR_CYCLE_CYC,
  parameter IDLE_CYC = `IDLE_HIGH_MIN_CYC
) (
  input wire core_clk_i,
  input wire rst_i,
  input wire line_i,
  output reg line_o,
  output reg line_oe_o,
  input wire address_select_low_i,
  input wire address_select_high_i,
  input wire shutdown_i,
  input wire [1:0] rate_sel_i,
  input wire read_bit_valid_i,
  input wire read_bit_i,
  output reg [1:0] address_o,
  output reg bit_valid_o,
  output reg bit_value_o,
  output reg frame_start_o,
  output reg frame_abort_o,
  output reg bus_reset_o,
  output reg conv_tick_o,
  output reg alert_busy_o
);
  localparam ST_POR = 3'h0;
  localparam ST_IDLE = 3'h1;
  localparam ST_READ1 = 3'h2;
  localparam ST_ALERT = 3'h3;
  localparam ST_WAIT = 3'h4;

  reg line_s1_reg, line_s2_reg;
  reg a0_s1_reg, a0_s2_reg, a1_s1_reg, a1_s2_reg;
  reg [2:0] state_reg;
  reg [CNT_W-1:0] drive_cnt_reg;
  reg [CNT_W-1:0] idle_cnt_reg;
  reg [MON_W-1:0] mon_cnt_reg;
  reg [3:0] bit_cnt_reg;
  reg alert_pend_reg;
  reg read_pend_reg, read_val_reg;
  reg in_frame_reg;
  wire line_low;
  wire fall;
  wire sym_valid;
  wire [2:0] sym_code;
  wire alert_ok;
  wire [MON_W-1:0] mon_limit;

  // monitoring cycle length scaled by rate selection
  function [MON_W-1:0] rate_limit;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: rate_limit = MONITOR_CYCLE_CYC[MON_W-1:0];
        2'h1: rate_limit = {1'b0, MONITOR_CYCLE_CYC[MON_W-1:1]};
        2'h2: rate_limit = {2'b00, MONITOR_CYCLE_CYC[MON_W-1:2]};
        default: rate_limit = {3'b000, MONITOR_CYCLE_CYC[MON_W-1:3]};
      endcase
    end
  endfunction

  // ***********************************
  // input synchronisers
  // ***********************************
  // two flops on the line and on the address straps
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      line_s1_reg <= 1'b1;
      line_s2_reg <= 1'b1;
      a0_s1_reg <= 1'b0;
      a0_s2_reg <= 1'b0;
      a1_s1_reg <= 1'b0;
      a1_s2_reg <= 1'b0;
    end else begin
      line_s1_reg <= line_i;
      line_s2_reg <= line_s1_reg;
      a0_s1_reg <= address_select_low_i;
      a0_s2_reg <= a0_s1_reg;
      a1_s1_reg <= address_select_high_i;
      a1_s2_reg <= a1_s1_reg;
    end
  end

  assign line_low = ~line_s2_reg;
  assign mon_limit = rate_limit(rate_sel_i);
  assign alert_ok = (idle_cnt_reg >= IDLE_CYC[CNT_W-1:0]) &&
                    (bit_cnt_reg >= `BITS_BEFORE_ALERT);

  // ***********************************
  // width classifier
  // ***********************************
  pulse_classifier #(
    .CNT_W(CNT_W)
  ) u_classifier (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .line_low_i(line_low),
    .fall_o(fall),
    .sym_valid_o(sym_valid),
    .sym_code_o(sym_code),
    .low_cnt_o()
  );

  // ***********************************
  // idle, conversion and bookkeeping
  // ***********************************
  // idle timer, monitoring cycle, address, read data capture
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      idle_cnt_reg <= {CNT_W{1'b0}};
      mon_cnt_reg <= {MON_W{1'b0}};
      conv_tick_o <= 1'b0;
      address_o <= 2'h0;
      read_pend_reg <= 1'b0;
      read_val_reg <= 1'b0;
    end else begin
      address_o <= {a1_s2_reg, a0_s2_reg};
      if (line_low) begin
        idle_cnt_reg <= {CNT_W{1'b0}};
      end else if (~&idle_cnt_reg) begin
        idle_cnt_reg <= idle_cnt_reg + 1'b1;
      end
      conv_tick_o <= 1'b0;
      if (shutdown_i) begin
        mon_cnt_reg <= {MON_W{1'b0}};
      end else if (mon_cnt_reg >= mon_limit - 1'b1) begin
        mon_cnt_reg <= {MON_W{1'b0}};
        conv_tick_o <= 1'b1;
      end else begin
        mon_cnt_reg <= mon_cnt_reg + 1'b1;
      end
      if (read_bit_valid_i) begin
        read_pend_reg <= 1'b1;
        read_val_reg <= read_bit_i;
      end else if (fall && state_reg == ST_IDLE) begin
        read_pend_reg <= 1'b0; // consumed by the opened bit
      end
    end
  end

  // ***********************************
  // line driver state machine
  // ***********************************
  // power-up reset, read-one stretch and alert pulses
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ST_POR;
      drive_cnt_reg <= {CNT_W{1'b0}};
      line_o <= 1'b0;
      line_oe_o <= 1'b0;
      alert_busy_o <= 1'b0;
      alert_pend_reg <= 1'b0;
    end else begin
      line_o <= 1'b0;
      if (conv_tick_o) begin
        alert_pend_reg <= 1'b1; // new data, set wins
      end
      case (state_reg)
        ST_POR: begin
          line_oe_o <= 1'b1;
          if (drive_cnt_reg >= RESET_DRIVE_CYC[CNT_W-1:0]) begin
            line_oe_o <= 1'b0;
            drive_cnt_reg <= {CNT_W{1'b0}};
            state_reg <= ST_WAIT;
          end else begin
            drive_cnt_reg <= drive_cnt_reg + 1'b1;
          end
        end
        ST_IDLE: begin
          line_oe_o <= 1'b0;
          drive_cnt_reg <= {CNT_W{1'b0}};
          if (fall && read_pend_reg && read_val_reg) begin
            line_oe_o <= 1'b1;
            state_reg <= ST_READ1;
          end else if (fall) begin
            state_reg <= ST_WAIT;
          end else if (alert_pend_reg && alert_ok && !shutdown_i) begin
            line_oe_o <= 1'b1;
            alert_busy_o <= 1'b1;
            alert_pend_reg <= conv_tick_o;
            state_reg <= ST_ALERT;
          end
        end
        ST_READ1: begin
          drive_cnt_reg <= drive_cnt_reg + 1'b1;
          if (drive_cnt_reg >= `READ_ONE_CYC - 1) begin
            line_oe_o <= 1'b0;
            state_reg <= ST_WAIT;
          end
        end
        ST_ALERT: begin
          drive_cnt_reg <= drive_cnt_reg + 1'b1;
          if (drive_cnt_reg >= `ALERT_CYC - 1) begin
            line_oe_o <= 1'b0;
            alert_busy_o <= 1'b0;
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          line_oe_o <= 1'b0;
          if (!line_low) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          line_oe_o <= 1'b0;
          state_reg <= ST_WAIT;
        end
      endcase
    end
  end

  // ***********************************
  // symbol handling
  // ***********************************
  // report symbols, count data bits, frame start, abort and reset
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bit_valid_o <= 1'b0;
      bit_value_o <= 1'b0;
      frame_start_o <= 1'b0;
      frame_abort_o <= 1'b0;
      bus_reset_o <= 1'b0;
      bit_cnt_reg <= 4'h0;
      in_frame_reg <= 1'b0;
    end else begin
      bit_valid_o <= 1'b0;
      frame_start_o <= 1'b0;
      frame_abort_o <= 1'b0;
      bus_reset_o <= 1'b0;
      if (sym_valid) begin
        case (sym_code)
          `SYM_ZERO, `SYM_ONE: begin
            bit_valid_o <= 1'b1;
            bit_value_o <= (sym_code == `SYM_ONE);
            if (bit_cnt_reg < `BITS_BEFORE_ALERT) begin
              bit_cnt_reg <= bit_cnt_reg + 1'b1;
            end
          end
          `SYM_START: begin
            frame_start_o <= 1'b1;
            frame_abort_o <= in_frame_reg;
            in_frame_reg <= 1'b1;
          end
          `SYM_RESET: begin
            bus_reset_o <= 1'b1;
            bit_cnt_reg <= 4'h0;
            in_frame_reg <= 1'b0;
          end
          default: begin
            in_frame_reg <= in_frame_reg; // alert: not a data bit
          end
        endcase
      end
    end
  end
endmodule // pulse_width_sensor_bus_slave

// >>> verif/pws_props.sv
// concurrent checks on the ports of the sensor bus slave
// assumes line_i is the wired bus level with the pull-up applied
`timescale 1ns/1ns
`include "pws_slave_regs.vh"
module pws_props #(
  parameter RESET_DRIVE_CYC = 88500,
  parameter MONITOR_CYCLE_CYC = 4000,
  parameter IDLE_CYC = 2750
) (
  input wire core_clk_i,
  input wire rst_i,
  input wire line_i,
  input wire line_o,
  input wire line_oe_o,
  input wire address_select_low_i,
  input wire address_select_high_i,
  input wire shutdown_i,
  input wire [1:0] rate_sel_i,
  input wire read_bit_valid_i,
  input wire read_bit_i,
  input wire [1:0] address_o,
  input wire bit_valid_o,
  input wire bit_value_o,
  input wire frame_start_o,
  input wire frame_abort_o,
  input wire bus_reset_o,
  input wire conv_tick_o,
  input wire alert_busy_o
);
  // ***********************************************
  // helper counters: drive, low and high run lengths
  // ***********************************************
  reg [19:0] oe_cnt, lo_cnt, hi_cnt, last_lo, gap;
  reg [4:0] nbit;
  reg up_done, gap_ok;
  wire [1:0] sel = {address_select_high_i, address_select_low_i};
  wire [19:0] per = MONITOR_CYCLE_CYC >> rate_sel_i;
  // run lengths; bit count restarts at every bus reset
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      oe_cnt <= 20'h0;
      lo_cnt <= 20'h0;
      hi_cnt <= 20'h0;
      last_lo <= 20'h0;
      gap <= 20'h0;
      nbit <= 5'h0;
      up_done <= 1'b0;
      gap_ok <= 1'b0;
    end else begin
      oe_cnt <= line_oe_o ? oe_cnt + 20'h1 : 20'h0;
      lo_cnt <= line_i ? 20'h0 : lo_cnt + 20'h1;
      hi_cnt <= line_i ? hi_cnt + 20'h1 : 20'h0;
      if (line_i && lo_cnt != 20'h0) last_lo <= lo_cnt;
      gap <= conv_tick_o ? 20'h0 : gap + 20'h1;
      if (bus_reset_o) nbit <= 5'h0;
      else if (bit_valid_o && nbit != 5'h1f) nbit <= nbit + 5'h1;
      up_done <= up_done | $fell(line_oe_o);
      gap_ok <= shutdown_i ? 1'b0 : (conv_tick_o | gap_ok);
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  line_low_a: assert property (line_o == 1'b0)
    else $error("line output not low");
  drive_width_a: assert property ($fell(line_oe_o) |->
    (!up_done && oe_cnt >= RESET_DRIVE_CYC && oe_cnt <= RESET_DRIVE_CYC + 1)
    || (oe_cnt >= 7075 && oe_cnt <= 9575)
    || (oe_cnt >= 41250 && oe_cnt <= 57000))
    else $error("drive width out of window");
  alert_drive_a: assert property (alert_busy_o |-> line_oe_o)
    else $error("alert without drive");
  alert_idle_a: assert property ($rose(alert_busy_o) |->
    hi_cnt >= IDLE_CYC && !$past(shutdown_i))
    else $error("alert without idle bus");
  alert_bits_a: assert property ($rose(alert_busy_o) |-> nbit >= 5'd14)
    else $error("alert before enough bits");
  edge_detect_a: assert property (
    $rose(line_oe_o) && !alert_busy_o && up_done |->
    lo_cnt >= 20'h1 && lo_cnt <= `EDGE_DETECT_CYC)
    else $error("late read drive");
  bit_width_a: assert property (bit_valid_o |->
    last_lo < `TH_START_CYC && bit_value_o == (last_lo >= `TH_ONE_CYC))
    else $error("bit value not from width");
  start_width_a: assert property (frame_start_o |->
    last_lo >= `TH_START_CYC && last_lo < `TH_ALERT_CYC)
    else $error("start not from width");
  abort_pair_a: assert property (frame_abort_o |-> frame_start_o)
    else $error("abort without start");
  one_symbol_a: assert property (
    $onehot0({bit_valid_o, frame_start_o, bus_reset_o}))
    else $error("two symbols at once");
  strap_addr_a: assert property ($stable(sel) [*5] |-> address_o == sel)
    else $error("address not from straps");
  tick_period_a: assert property (conv_tick_o && gap_ok |->
    gap + 20'h2 >= per && gap <= per)
    else $error("monitoring period wrong");
  shut_quiet_a: assert property (shutdown_i ##1 shutdown_i |-> !conv_tick_o)
    else $error("tick in shutdown");
  cover property ($fell(line_oe_o) && oe_cnt < 20'd20000);
  cover property ($rose(alert_busy_o));
  cover property (frame_abort_o);
endmodule // pws_props
bind pulse_width_sensor_bus_slave pws_props #(
  .RESET_DRIVE_CYC(RESET_DRIVE_CYC), .MONITOR_CYCLE_CYC(MONITOR_CYCLE_CYC),
  .IDLE_CYC(IDLE_CYC)) props_u (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .line_i(line_i), .line_o(line_o), .line_oe_o(line_oe_o),
  .address_select_low_i(address_select_low_i),
  .address_select_high_i(address_select_high_i), .shutdown_i(shutdown_i),
  .rate_sel_i(rate_sel_i), .read_bit_valid_i(read_bit_valid_i),
  .read_bit_i(read_bit_i), .address_o(address_o),
  .bit_valid_o(bit_valid_o), .bit_value_o(bit_value_o),
  .frame_start_o(frame_start_o), .frame_abort_o(frame_abort_o),
  .bus_reset_o(bus_reset_o), .conv_tick_o(conv_tick_o),
  .alert_busy_o(alert_busy_o));

// >>> verif/host_bus_model.sv
// host side of the single-wire bus: opens every symbol as a low pulse
// assumes line_i is the wired level with the pull-up applied
`timescale 1ns/1ns
module host_bus_model (
  input wire core_clk_i,
  input wire line_i,
  output reg pull_o
);
  integer hi;
  initial pull_o = 1'b0;
  // wait for an idle bus, pull low, then time the whole low phase
  task send(input integer low_cyc, output integer seen);
    begin
      hi = 0;
      while (hi < 2800) begin
        @(posedge core_clk_i);
        hi = line_i ? hi + 1 : 0;
      end
      pull_o <= 1'b1;
      repeat (low_cyc) @(posedge core_clk_i);
      pull_o <= 1'b0;
      seen = low_cyc;
      @(posedge core_clk_i);
      while (!line_i && seen < 60000) begin
        @(posedge core_clk_i);
        seen = seen + 1;
      end
    end
  endtask
endmodule // host_bus_model

// >>> verif/pulse_width_sensor_bus_slave_tb_top.sv
// self-checking bench for the sensor bus slave
// assumes host_bus_model as far side and a pull-up on the wire
`timescale 1ns/1ns
module pulse_width_sensor_bus_slave_tb_top;
  localparam MON = 4000;
  localparam RST_DRV = 88500;
  reg core_clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg shut = 1'b0;
  reg rd_v = 1'b0;
  reg rd_b = 1'b0;
  reg [1:0] rate = 2'h0;
  reg [1:0] strap = 2'h0;
  reg last_v = 1'b0;
  reg al_seen = 1'b0;
  wire m_pull, line_o, line_oe_o, bit_valid_o, bit_value_o;
  wire frame_start_o, frame_abort_o, bus_reset_o, conv_tick_o, alert_busy_o;
  wire [1:0] address_o;
  wire line_w = ~(line_oe_o | m_pull);
  integer mismatches = 0, checks_done = 0;
  integer nbit = 0, nstart = 0, nabort = 0, ntick = 0, nrst = 0;
  integer i, seen, w, nb, ns, na, nt, per;
  // ***********************************************
  // clock, design, host model and symbol counters
  // ***********************************************
  initial forever #2 core_clk_i = ~core_clk_i;
  pulse_width_sensor_bus_slave #(.RESET_DRIVE_CYC(RST_DRV),
    .MONITOR_CYCLE_CYC(MON)) dut_u (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .line_i(line_w), .line_o(line_o),
    .line_oe_o(line_oe_o), .address_select_low_i(strap[0]),
    .address_select_high_i(strap[1]), .shutdown_i(shut),
    .rate_sel_i(rate), .read_bit_valid_i(rd_v), .read_bit_i(rd_b),
    .address_o(address_o), .bit_valid_o(bit_valid_o),
    .bit_value_o(bit_value_o), .frame_start_o(frame_start_o),
    .frame_abort_o(frame_abort_o), .bus_reset_o(bus_reset_o),
    .conv_tick_o(conv_tick_o), .alert_busy_o(alert_busy_o));
  host_bus_model m_u (.core_clk_i(core_clk_i), .line_i(line_w),
    .pull_o(m_pull));
  // count each one-cycle symbol pulse
  always @(posedge core_clk_i) begin
    if (bit_valid_o === 1'b1) nbit <= nbit + 1;
    if (bit_valid_o === 1'b1) last_v <= bit_value_o;
    if (frame_start_o === 1'b1) nstart <= nstart + 1;
    if (frame_abort_o === 1'b1) nabort <= nabort + 1;
    if (conv_tick_o === 1'b1) ntick <= ntick + 1;
    if (bus_reset_o === 1'b1) nrst <= nrst + 1;
    if (alert_busy_o === 1'b1) al_seen <= 1'b1;
  end
  task check(input [31:0] got, input [31:0] exp, input [8*12:1] what);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("ERROR %0s expected %0h seen %0h", what, exp, got);
      end
    end
  endtask
  // expected total low seen by the host on a read bit
  function read_low_ok(input reg v, input integer s);
    begin
      read_low_ok = v ? (s > 7074 && s < 9600) : (s < 3002);
    end
  endfunction
  task results;
    begin
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  // one data bit from the host; rd asks the slave to answer v
  task xbit(input reg rd, input reg v);
    begin
      if (rd) begin
        rd_v <= 1'b1;
        rd_b <= v;
        @(posedge core_clk_i);
        rd_v <= 1'b0;
      end
      nb = nbit;
      w = rd ? 3000 : v ? 8850 + $urandom % 3375 : 2950 + $urandom % 1300;
      m_u.send(w, seen);
      repeat (8) @(posedge core_clk_i);
      check(nbit - nb, 1, "bit count");
      check(last_v, v, "bit value");
      check(al_seen, 0, "early alert");
      if (rd) check(read_low_ok(v, seen), 1, "read low");
    end
  endtask
  // start pulse; ab expects the open frame to be dropped
  task xstart(input reg ab);
    begin
      nb = nbit;
      ns = nstart;
      na = nabort;
      m_u.send(20000 + $urandom % 7000, seen);
      repeat (8) @(posedge core_clk_i);
      check(nstart - ns, 1, "start");
      check(nbit - nb, 0, "start bits");
      check(nabort - na, ab, "abort");
    end
  endtask
  initial begin
    i = $urandom(6261);
    @(posedge core_clk_i);
    rate <= $urandom % 4;
    strap <= $urandom % 4;
    repeat (16) @(posedge core_clk_i);
    rst_i <= 1'b0;
    per = MON >> rate;
    repeat (4) @(posedge core_clk_i);
    check(line_oe_o, 1, "pwrup drive");
    check(address_o, strap, "address");
    repeat (RST_DRV + 8) @(posedge core_clk_i);
    check(line_oe_o, 0, "pwrup end");
    check(nrst, 1, "bus reset");
    shut <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    nt = ntick;
    repeat (3 * per) @(posedge core_clk_i);
    check(ntick - nt, 0, "shut ticks");
    shut <= 1'b0;
    repeat (3 * per + 8) @(posedge core_clk_i);
    check(ntick - nt >= 2, 1, "ticks");
    xbit(0, 1);
    xbit(0, 0);
    xstart(0);
    xbit(1, 1);
    xbit(1, 0);
    for (i = 0; i < 8; i = i + 1) xbit(0, $urandom % 4 == 0);
    xstart(1);
    xbit(0, 0);
    xbit(0, 1);
    i = 0;
    while (alert_busy_o !== 1'b1 && i < 2 * per + 4000) begin
      @(posedge core_clk_i);
      i = i + 1;
    end
    check(alert_busy_o, 1, "alert");
    i = 0;
    while (line_w === 1'b0 && i < 60000) begin
      @(posedge core_clk_i);
      i = i + 1;
    end
    check(i >= 41240 && i <= 57000, 1, "alert width");
    shut <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    results;
  end
  // cut a hang short
  initial begin
    #2000000;
    mismatches = mismatches + 1;
    results;
  end
endmodule // pulse_width_sensor_bus_slave_tb_top
